// >>> include/dpt_map.svh
// Offsets, field positions, reset values and timing counts of the power-down and termination block.
`ifndef DPT_MAP_SVH
`define DPT_MAP_SVH

// ============================================================
// Clock
// ============================================================
`define DPT_CLK_PERIOD_PS 40000

// ============================================================
// Register offsets (byte addresses)
// ============================================================
`define DPT_OFS_CTRL 8'h00
`define DPT_OFS_LAT 8'h04
`define DPT_OFS_STATUS 8'h08

// ============================================================
// Control register fields
// ============================================================
`define DPT_CTRL_FAST_EXIT 0
`define DPT_CTRL_NOM_LO 1
`define DPT_CTRL_NOM_HI 3
`define DPT_CTRL_TDQS 4
`define DPT_CTRL_WR_LO 5
`define DPT_CTRL_WR_HI 6
`define DPT_CTRL_DLL_OFF 7
`define DPT_CTRL_X8 8
`define DPT_CTRL_RST 9'h000

// ============================================================
// Latency register fields
// ============================================================
`define DPT_LAT_CWL_LO 0
`define DPT_LAT_CWL_HI 3
`define DPT_LAT_AL_LO 4
`define DPT_LAT_AL_HI 7
`define DPT_LAT_RST 8'h05

// ============================================================
// Status register fields
// ============================================================
`define DPT_ST_STATE_LO 0
`define DPT_ST_STATE_HI 2
`define DPT_ST_FROZEN 3
`define DPT_ST_CMD_RX 4
`define DPT_ST_RTT 5
`define DPT_ST_LOWPWR 6
`define DPT_ST_SYNC 7
`define DPT_ST_BANK_LO 8
`define DPT_ST_BANK_HI 15

// ============================================================
// Timing
// ============================================================
`define DPT_TCPDED_NCK 4'h1
`define DPT_T_ROWOP_NS 15
`define DPT_T_REF_NS 160
`define DPT_ROWOP_CYC (((`DPT_T_ROWOP_NS * 1000) + `DPT_CLK_PERIOD_PS - 1) / `DPT_CLK_PERIOD_PS)
`define DPT_REF_CYC (((`DPT_T_REF_NS * 1000) + `DPT_CLK_PERIOD_PS - 1) / `DPT_CLK_PERIOD_PS)
`define DPT_ODTL_OFFSET 5'h02
`define DPT_ODT_PIPE 32

`endif

// >>> include/dpt_pkg.sv
// Types shared by the power-down and termination block.
package dpt_pkg;

    typedef enum logic [2:0] {
        DPT_ST_IDLE = 3'b000,
        DPT_ST_PD_ENTRY = 3'b001,
        DPT_ST_PD_ACT = 3'b010,
        DPT_ST_PD_PRE_FAST = 3'b011,
        DPT_ST_PD_PRE_SLOW = 3'b100,
        DPT_ST_SELF_REF = 3'b101
    } dpt_pd_state_t;

    typedef enum logic [2:0] {
        DPT_CMD_NOP = 3'b000,
        DPT_CMD_ACT = 3'b001,
        DPT_CMD_PRE = 3'b010,
        DPT_CMD_REF = 3'b011,
        DPT_CMD_OTHER = 3'b100
    } dpt_cmd_t;

endpackage : dpt_pkg

// >>> include/dpt_odt_if.sv
// Carrier between the power-down core and the termination latency pipeline.
`timescale 1ns/10ps
`default_nettype none

interface dpt_odt_if;
    logic odt_req;
    logic sync_mode;
    logic direct_mode;
    logic [4:0] latency;
    logic rtt_on;

    modport core (output odt_req, output sync_mode, output direct_mode, output latency,
                  input rtt_on);
    modport pipe (input odt_req, input sync_mode, input direct_mode, input latency,
                  output rtt_on);
endinterface : dpt_odt_if

`default_nettype wire

// >>> rtl/dpt_odt_pipe.sv
// Termination latency pipeline: delays the termination request by the programmed latency in sync mode, without it in direct mode, off otherwise.
`timescale 1ns/10ps
`default_nettype none
`include "dpt_map.svh"

module dpt_odt_pipe
    import dpt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link to the core
    dpt_odt_if.pipe odt
);

    typedef struct packed {
        logic [`DPT_ODT_PIPE-1:0] shift;
        logic rtt;
    } dpt_pipe_state_t;

    dpt_pipe_state_t s_q;
    dpt_pipe_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.shift = {s_q.shift[`DPT_ODT_PIPE-2:0], odt.odt_req};
        if (odt.sync_mode) begin
            // Sample taken at edge n becomes visible after edge n plus the latency.
            s_d.rtt = s_q.shift[odt.latency - 5'h01];
        end else if (odt.direct_mode) begin
            s_d.rtt = odt.odt_req;
        end else begin
            s_d.rtt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign odt.rtt_on = s_q.rtt;

endmodule : dpt_odt_pipe

`default_nettype wire

// >>> rtl/dpt_pd_odt.sv
// Power-down entry and exit, DLL handling and termination control of the DRAM device.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "dpt_map.svh"

module dpt_pd_odt
    import dpt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // DRAM command pins, sampled on the rising clock edge
    input wire logic mem_cke,
    input wire logic mem_odt,
    input wire logic mem_reset_n,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic mem_a10,
    input wire logic [2:0] mem_ba,
    // DLL status
    input wire logic dll_locked,
    // Device-side controls
    output logic io_buf_en,
    output logic cmd_rx_en,
    output logic dll_run,
    output logic low_power,
    output logic rtt_dq_en,
    output logic rtt_tdqs_en,
    output logic [2:0] rtt_nom_code,
    output logic [1:0] rtt_wr_code
);

    // ============================================================
    // Helpers
    // ============================================================
    function automatic dpt_cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n);
        dpt_cmd_t c;
        c = DPT_CMD_OTHER;
        if (cs_n) begin
            c = DPT_CMD_NOP;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'b111: c = DPT_CMD_NOP;
                3'b011: c = DPT_CMD_ACT;
                3'b010: c = DPT_CMD_PRE;
                3'b001: c = DPT_CMD_REF;
                default: c = DPT_CMD_OTHER;
            endcase
        end
        return c;
    endfunction

    // ============================================================
    // State
    // ============================================================
    typedef struct packed {
        logic [8:0] ctrl;
        logic [7:0] lat;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] rst_sync;
        logic rst_n_filt;
        logic cke_prev;
        dpt_pd_state_t state;
        logic [7:0] bank_open;
        logic [3:0] busy;
        logic [3:0] cpded;
        logic rx_en;
        logic buf_en;
        logic lowpwr;
        logic dll_on;
        logic rtt_dq;
        logic rtt_tdqs;
        logic [2:0] nom;
        logic [1:0] wr;
    } dpt_state_t;

    dpt_state_t s_q;
    dpt_state_t s_d;

    dpt_odt_if odt_link ();

    dpt_cmd_t cmd;
    logic nop_des;
    logic in_pd;
    logic frozen;
    logic dll_off;
    logic odt_mr_en;
    logic wb_req;
    logic [15:0] status;

    dpt_odt_pipe u_pipe (
        .sys_clk(sys_clk),
        .rst(rst),
        .odt(odt_link.pipe)
    );

    // ============================================================
    // Combinational decode
    // ============================================================
    always_comb begin
        cmd = decode_cmd(mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n);
        nop_des = (cmd == DPT_CMD_NOP);
        in_pd = (s_q.state == DPT_ST_PD_ENTRY) || (s_q.state == DPT_ST_PD_ACT) ||
                (s_q.state == DPT_ST_PD_PRE_FAST) || (s_q.state == DPT_ST_PD_PRE_SLOW);
        frozen = (s_q.state == DPT_ST_PD_PRE_SLOW);
        dll_off = s_q.ctrl[`DPT_CTRL_DLL_OFF];
        odt_mr_en = (s_q.ctrl[`DPT_CTRL_NOM_HI:`DPT_CTRL_NOM_LO] != 3'h0) ||
                    (s_q.ctrl[`DPT_CTRL_WR_HI:`DPT_CTRL_WR_LO] != 2'h0);
        wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;
        status = '0;
        status[`DPT_ST_STATE_HI:`DPT_ST_STATE_LO] = s_q.state;
        status[`DPT_ST_FROZEN] = frozen;
        status[`DPT_ST_CMD_RX] = s_q.rx_en;
        status[`DPT_ST_RTT] = odt_link.rtt_on;
        status[`DPT_ST_LOWPWR] = s_q.lowpwr;
        status[`DPT_ST_SYNC] = odt_link.sync_mode;
        status[`DPT_ST_BANK_HI:`DPT_ST_BANK_LO] = s_q.bank_open;
    end

    // Termination request and timing mode handed to the pipeline.
    assign odt_link.odt_req = mem_odt && odt_mr_en && !dll_off &&
                              (s_q.state != DPT_ST_SELF_REF);
    assign odt_link.sync_mode = s_q.dll_on && dll_locked && !frozen;
    assign odt_link.direct_mode = frozen;
    assign odt_link.latency = 5'(s_q.lat[`DPT_LAT_CWL_HI:`DPT_LAT_CWL_LO]) +
                              5'(s_q.lat[`DPT_LAT_AL_HI:`DPT_LAT_AL_LO]) -
                              `DPT_ODTL_OFFSET;

    // ============================================================
    // Next state
    // ============================================================
    always_comb begin
        s_d = s_q;

        // Register bus: one wait state, unmapped reads return zero.
        s_d.ack = wb_req;
        if (wb_req) begin
            s_d.rdata = '0;
            case (wb_adr_i)
                `DPT_OFS_CTRL: begin
                    s_d.rdata[8:0] = s_q.ctrl;
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_d.ctrl[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_we_i && wb_sel_i[1]) begin
                        s_d.ctrl[8] = wb_dat_i[8];
                    end
                end
                `DPT_OFS_LAT: begin
                    s_d.rdata[7:0] = s_q.lat;
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_d.lat = wb_dat_i[7:0];
                    end
                end
                `DPT_OFS_STATUS: begin
                    s_d.rdata[15:0] = status;
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        // Reset pin: three flops, a change counts when the last two agree.
        s_d.rst_sync = {s_q.rst_sync[1:0], mem_reset_n};
        if (s_q.rst_sync[2] == s_q.rst_sync[1]) begin
            s_d.rst_n_filt = s_q.rst_sync[2];
        end

        s_d.cke_prev = mem_cke;
        if (s_q.busy != 4'h0) begin
            s_d.busy = s_q.busy - 4'h1;
        end

        case (s_q.state)
            DPT_ST_IDLE: begin
                // Bank tracking from the commands seen while awake.
                if (mem_cke && s_q.cke_prev) begin
                    case (cmd)
                        DPT_CMD_ACT: begin
                            s_d.bank_open[mem_ba] = 1'b1;
                            s_d.busy = 4'(`DPT_ROWOP_CYC);
                        end
                        DPT_CMD_PRE: begin
                            if (mem_a10) begin
                                s_d.bank_open = '0;
                            end else begin
                                s_d.bank_open[mem_ba] = 1'b0;
                            end
                            s_d.busy = 4'(`DPT_ROWOP_CYC);
                        end
                        DPT_CMD_REF: begin
                            s_d.busy = 4'(`DPT_REF_CYC);
                        end
                        default: begin
                        end
                    endcase
                end
                if (!mem_cke && s_q.cke_prev) begin
                    if (cmd == DPT_CMD_REF) begin
                        s_d.state = DPT_ST_SELF_REF;
                        s_d.bank_open = '0;
                    end else if (nop_des) begin
                        s_d.state = DPT_ST_PD_ENTRY;
                    end
                    s_d.cpded = `DPT_TCPDED_NCK;
                    s_d.buf_en = 1'b0;
                end
            end
            DPT_ST_PD_ENTRY: begin
                // In-flight row operations run to completion first.
                if (s_q.busy == 4'h0) begin
                    if (s_q.bank_open != 8'h00) begin
                        s_d.state = DPT_ST_PD_ACT;
                    end else if (s_q.ctrl[`DPT_CTRL_FAST_EXIT]) begin
                        s_d.state = DPT_ST_PD_PRE_FAST;
                    end else begin
                        s_d.state = DPT_ST_PD_PRE_SLOW;
                    end
                    s_d.lowpwr = 1'b1;
                end
            end
            DPT_ST_PD_ACT, DPT_ST_PD_PRE_FAST, DPT_ST_PD_PRE_SLOW: begin
            end
            DPT_ST_SELF_REF: begin
                if (mem_cke) begin
                    s_d.state = DPT_ST_IDLE;
                end
            end
            default: begin
                s_d.state = DPT_ST_IDLE;
            end
        endcase

        // Receivers go off once the entry window has run out.
        if (in_pd || (s_q.state == DPT_ST_SELF_REF)) begin
            if (s_q.cpded != 4'h0) begin
                s_d.cpded = s_q.cpded - 4'h1;
            end else begin
                s_d.rx_en = 1'b0;
            end
        end

        if (in_pd && mem_cke && nop_des) begin
            s_d.state = DPT_ST_IDLE;
        end
        if (s_d.state == DPT_ST_IDLE) begin
            s_d.rx_en = 1'b1;
            s_d.lowpwr = 1'b0;
            if (mem_cke) begin
                s_d.buf_en = 1'b1;
            end
        end

        // Termination switch outputs follow the pipeline.
        s_d.rtt_dq = odt_link.rtt_on;
        s_d.rtt_tdqs = odt_link.rtt_on && s_q.ctrl[`DPT_CTRL_X8] &&
                       s_q.ctrl[`DPT_CTRL_TDQS];
        s_d.nom = s_q.ctrl[`DPT_CTRL_NOM_HI:`DPT_CTRL_NOM_LO];
        s_d.wr = s_q.ctrl[`DPT_CTRL_WR_HI:`DPT_CTRL_WR_LO];

        // Filtered reset pin low leaves any power-down state on the next edge.
        if (!s_q.rst_n_filt) begin
            s_d.state = DPT_ST_IDLE;
            s_d.bank_open = '0;
            s_d.busy = 4'h0;
            s_d.cpded = 4'h0;
            s_d.rx_en = 1'b1;
            s_d.buf_en = 1'b1;
            s_d.lowpwr = 1'b0;
        end

        // DLL runs except in slow exit, self-refresh or DLL-off mode.
        s_d.dll_on = !dll_off && (s_d.state != DPT_ST_PD_PRE_SLOW) &&
                     (s_d.state != DPT_ST_SELF_REF);
    end

    // ============================================================
    // Registers
    // ============================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.ctrl <= `DPT_CTRL_RST;
            s_q.lat <= `DPT_LAT_RST;
            s_q.rst_sync <= 3'b111;
            s_q.rst_n_filt <= 1'b1;
            s_q.cke_prev <= 1'b1;
            s_q.state <= DPT_ST_IDLE;
            s_q.rx_en <= 1'b1;
            s_q.buf_en <= 1'b1;
            s_q.dll_on <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign io_buf_en = s_q.buf_en;
    assign cmd_rx_en = s_q.rx_en;
    assign dll_run = s_q.dll_on;
    assign low_power = s_q.lowpwr;
    assign rtt_dq_en = s_q.rtt_dq;
    assign rtt_tdqs_en = s_q.rtt_tdqs;
    assign rtt_nom_code = s_q.nom;
    assign rtt_wr_code = s_q.wr;

endmodule : dpt_pd_odt

`default_nettype wire

// >>> tb/dpt_pd_odt_chk.sv
// Assertion checker for the power-down and termination block.
`timescale 1ns/10ps
`default_nettype none

module dpt_pd_odt_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Memory pins
    input wire logic mem_cke,
    input wire logic mem_odt,
    input wire logic mem_reset_n,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    // Device controls
    input wire logic io_buf_en,
    input wire logic cmd_rx_en,
    input wire logic dll_run,
    input wire logic low_power,
    input wire logic rtt_dq_en,
    input wire logic rtt_tdqs_en,
    input wire logic [2:0] rtt_nom_code,
    input wire logic [1:0] rtt_wr_code
);
    logic [8:0] ctrl_q;
    logic nop;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Shadow of the control word, taken on the edge that accepts a write.
    assign nop = mem_cs_n || (mem_ras_n && mem_cas_n && mem_we_n);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= 9'h000;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00) begin
            if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl_q[8] <= wb_dat_i[8];
        end
    end

    sequence s_entry;
        !mem_cke && $past(mem_cke) && nop && io_buf_en && mem_reset_n;
    endsequence

    a_entry_bufs:
        assert property (s_entry |=> !io_buf_en)
        else $error("buffers on after entry");
    a_rx_hold:
        assert property (s_entry |=> cmd_rx_en)
        else $error("receivers off too early");
    a_rx_off:
        assert property (s_entry ##1 !mem_cke ##1 !mem_cke |=> !cmd_rx_en)
        else $error("receivers still on");
    a_exit_wake:
        assert property (!io_buf_en && mem_cke && nop && mem_reset_n |=> io_buf_en && cmd_rx_en)
        else $error("no wake on exit");
    a_fast_dll:
        assert property (low_power && ctrl_q[0] && !$past(ctrl_q[7]) |-> dll_run)
        else $error("dll stopped in fast exit");
    a_dll_stop:
        assert property (!dll_run && !$past(ctrl_q[7]) |-> !io_buf_en)
        else $error("dll stopped outside power-down");
    a_rtt_mode:
        assert property (rtt_dq_en |-> rtt_nom_code != 3'h0 || rtt_wr_code != 2'h0)
        else $error("termination with fields zero");
    a_tdqs_and:
        assert property (rtt_tdqs_en |-> $past(ctrl_q[8]) && $past(ctrl_q[4]) && rtt_dq_en)
        else $error("tdqs termination unexpected");
    a_rtt_quiet:
        assert property (!mem_odt [*8] |=> !rtt_dq_en)
        else $error("termination on with odt low");
    a_reset_pd:
        assert property (!mem_reset_n [*5] |=> io_buf_en && cmd_rx_en && !low_power)
        else $error("reset did not leave power-down");

    c_entry: cover property (s_entry);
    c_slow: cover property (!dll_run && low_power);
    c_rtt: cover property (rtt_tdqs_en);
endmodule // dpt_pd_odt_chk

bind dpt_pd_odt dpt_pd_odt_chk u_chk (.*);

`default_nettype wire

// >>> tb/dpt_ctl_model.sv
// Behavioural memory controller driving the command, CKE and termination pins.
`timescale 1ns/10ps
`default_nettype none

module dpt_ctl_model
    import dpt_pkg::*;
#(
    parameter int TCKE = 3,
    parameter int TXP = 3,
    parameter int TXPDLL = 10,
    parameter int ODTH4 = 4
) (
    // Clock
    input wire logic sys_clk,
    // Memory pins
    output logic mem_cke,
    output logic mem_odt,
    output logic mem_reset_n,
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic mem_a10,
    output logic [2:0] mem_ba
);
    logic [7:0] bank_open_q;
    int odt_age;

    initial begin
        {mem_cke, mem_odt, mem_reset_n, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = 7'h5F;
        {mem_a10, mem_ba} = 4'h0;
        bank_open_q = 8'h00;
        odt_age = 0;
    end

    always @(posedge sys_clk) begin
        odt_age <= mem_odt ? odt_age + 1 : 0;
    end

    // One command at the given CKE level; deselected lines then toggle as don't-care.
    task automatic cmd(input dpt_cmd_t kind, input logic [2:0] ba, input logic a10,
                       input logic cke);
        @(posedge sys_clk);
        mem_cke <= cke;
        mem_cs_n <= (kind == DPT_CMD_NOP);
        {mem_ras_n, mem_cas_n, mem_we_n} <= (kind == DPT_CMD_ACT) ? 3'h3 :
                                            (kind == DPT_CMD_PRE) ? 3'h2 : 3'h1;
        {mem_a10, mem_ba} <= {a10, ba};
        if (kind == DPT_CMD_ACT) bank_open_q[ba] <= 1'b1;
        if (kind == DPT_CMD_PRE) bank_open_q <= a10 ? 8'h00 : bank_open_q & ~(8'h01 << ba);
        @(posedge sys_clk);
        mem_cs_n <= 1'b1;
        {mem_ras_n, mem_cas_n, mem_we_n, mem_a10, mem_ba} <= ~{mem_ras_n, mem_cas_n, mem_we_n, a10, ba};
    endtask

    task automatic pd_enter();
        cmd(DPT_CMD_NOP, 3'h0, 1'b0, 1'b0);
        repeat (TCKE) @(posedge sys_clk);
    endtask

    task automatic pd_exit(input logic slow);
        cmd(DPT_CMD_NOP, 3'h0, 1'b0, 1'b1);
        repeat ((slow && bank_open_q == 8'h00) ? TXPDLL : TXP) @(posedge sys_clk);
    endtask

    task automatic odt_set(input logic v);
        @(posedge sys_clk);
        while (!v && mem_odt && odt_age < ODTH4) @(posedge sys_clk);
        mem_odt <= v;
    endtask

    task automatic reset_pulse(input int n);
        @(posedge sys_clk);
        mem_reset_n <= 1'b0;
        bank_open_q <= 8'h00;
        repeat (n) @(posedge sys_clk);
        mem_reset_n <= 1'b1;
    endtask
endmodule // dpt_ctl_model

`default_nettype wire

// >>> tb/dpt_pd_odt_tb_top.sv
// Self-checking testbench of the power-down and termination block.
`timescale 1ns/10ps
`default_nettype none

module dpt_pd_odt_tb_top
    import dpt_pkg::*;
;
    logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dll_locked;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic mem_cke, mem_odt, mem_reset_n, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_a10;
    logic [2:0] mem_ba, rtt_nom_code;
    logic [1:0] rtt_wr_code;
    logic io_buf_en, cmd_rx_en, dll_run, low_power, rtt_dq_en, rtt_tdqs_en;
    logic [7:0] lats [3] = '{8'h16, 8'h08, 8'h05};
    int errors, n_tests, cycles;

    dpt_pd_odt u_dpt_pd_odt (.*);
    dpt_ctl_model u_dpt_ctl_model (.*);

    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wbs(input logic [3:0] sel, input logic we, input logic [7:0] adr,
                       input logic [31:0] dat);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'h3, we, sel, adr, dat};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_sel_i} <= 6'h00;
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wbs(4'hF, we, adr, dat);
    endtask

    task automatic chk_st(input string name, input logic [15:0] exp);
        wb(1'b0, 8'h08, 32'h0);
        chk(name, {16'h0000, exp}, rd);
    endtask

    // Counts edges from the termination pin change until the enable follows it.
    task automatic odt_meas(input logic v, input logic [7:0] lat, input logic t);
        int k;
        u_dpt_ctl_model.odt_set(v);
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rtt_dq_en !== v);
        chk("odt_latency", int'(lat[3:0]) + int'(lat[7:4]) + 1, k);
        @(posedge sys_clk);
        chk("tdqs_rtt", 32'(v & t), 32'(rtt_tdqs_en));
    endtask

    initial begin
        {sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, dll_locked} = 6'h11;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'h0, 32'h0};
        {errors, n_tests, cycles} = {32'd0, 32'd0, 32'd0};
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        wb(1'b0, 8'h04, 32'h0);
        chk("lat_reset", 32'h5, rd);
        wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, 8'h08, 32'hFFFF_FFFF);
        chk_st("status_reset", 16'h0090);
        wbs(4'h2, 1'b1, 8'h00, 32'h0000_01FF);
        wbs(4'hE, 1'b1, 8'h04, 32'h0000_00FF);
        wb(1'b0, 8'h00, 32'h0);
        chk("sel_ctrl", 32'h100, rd);
        wb(1'b0, 8'h04, 32'h0);
        chk("sel_lat", 32'h5, rd);
        wb(1'b1, 8'h00, 32'h1);
        u_dpt_ctl_model.cmd(DPT_CMD_PRE, 3'h0, 1'b1, 1'b1);
        u_dpt_ctl_model.pd_enter();
        chk_st("fast_pd", 16'h00C3);
        chk("fast_dll", 32'h1, 32'(dll_run));
        u_dpt_ctl_model.pd_exit(1'b0);
        chk("exit_bufs", 32'h3, {30'h0, io_buf_en, cmd_rx_en});
        wb(1'b1, 8'h00, 32'h0);
        u_dpt_ctl_model.pd_enter();
        chk_st("slow_pd", 16'h004C);
        chk("slow_dll", 32'h0, 32'(dll_run));
        u_dpt_ctl_model.cmd(DPT_CMD_REF, 3'h0, 1'b0, 1'b1);
        #1;
        chk("refused_exit", 32'h0, 32'(io_buf_en));
        u_dpt_ctl_model.pd_exit(1'b1);
        chk_st("slow_exit", 16'h0090);
        u_dpt_ctl_model.cmd(DPT_CMD_REF, 3'h0, 1'b0, 1'b1);
        u_dpt_ctl_model.cmd(DPT_CMD_NOP, 3'h0, 1'b0, 1'b0);
        #1;
        chk("busy_lowpwr", 32'h0, 32'(low_power));
        repeat (8) @(posedge sys_clk);
        chk_st("ref_pd", 16'h004C);
        u_dpt_ctl_model.pd_exit(1'b1);
        u_dpt_ctl_model.cmd(DPT_CMD_ACT, 3'h3, 1'b0, 1'b1);
        u_dpt_ctl_model.pd_enter();
        chk_st("act_pd", 16'h08C2);
        chk("act_dll", 32'h1, 32'(dll_run));
        u_dpt_ctl_model.reset_pulse(6);
        repeat (2) @(posedge sys_clk);
        chk("reset_pd", 32'h3, {30'h0, io_buf_en, cmd_rx_en});
        u_dpt_ctl_model.pd_exit(1'b0);
        chk_st("reset_idle", 16'h0090);
        dll_locked <= 1'b0;
        chk_st("unlocked", 16'h0010);
        u_dpt_ctl_model.pd_enter();
        u_dpt_ctl_model.pd_exit(1'b1);
        // The DLL is reset after an unlocked entry and locks again.
        dll_locked <= 1'b1;
        chk_st("relocked", 16'h0090);
        wb(1'b1, 8'h00, 32'h112);
        foreach (lats[i]) begin
            wb(1'b1, 8'h04, {24'h0, lats[i]});
            odt_meas(1'b1, lats[i], 1'b1);
            chk("nom_code", 32'h1, 32'(rtt_nom_code));
            odt_meas(1'b0, lats[i], 1'b1);
        end
        // Frozen DLL: termination follows the pin without the latency.
        u_dpt_ctl_model.pd_enter();
        odt_meas(1'b1, 8'h02, 1'b1);
        odt_meas(1'b0, 8'h02, 1'b1);
        u_dpt_ctl_model.pd_exit(1'b1);
        wb(1'b1, 8'h00, 32'h020);
        odt_meas(1'b1, 8'h05, 1'b0);
        chk("wr_code", 32'h1, 32'(rtt_wr_code));
        odt_meas(1'b0, 8'h05, 1'b0);
        wb(1'b1, 8'h00, 32'h0);
        u_dpt_ctl_model.odt_set(1'b1);
        repeat (10) @(posedge sys_clk);
        chk("rtt_disabled", 32'h0, 32'(rtt_dq_en));
        u_dpt_ctl_model.odt_set(1'b0);
        wb(1'b1, 8'h00, 32'h080);
        chk_st("dll_off", 16'h0010);
        chk("dll_off_run", 32'h0, 32'(dll_run));
        wb(1'b1, 8'h00, 32'h002);
        u_dpt_ctl_model.cmd(DPT_CMD_REF, 3'h0, 1'b0, 1'b0);
        u_dpt_ctl_model.odt_set(1'b1);
        repeat (10) @(posedge sys_clk);
        chk("rtt_selfref", 32'h0, 32'(rtt_dq_en));
        wb(1'b0, 8'h08, 32'h0);
        chk("selfref_state", 32'h5, 32'(rd[2:0]));
        u_dpt_ctl_model.odt_set(1'b0);
        u_dpt_ctl_model.pd_exit(1'b1);
        end_of_test();
    end
endmodule // dpt_pd_odt_tb_top

`default_nettype wire
